// >>> rtl/bdiv_cfg.svh
// board decode and interrupt vectoring: offsets, field positions, reset values
`ifndef BDIV_CFG_SVH
`define BDIV_CFG_SVH
`define BDIV_BLOCK_HI       16'hFF84
`define BDIV_IDX_HI_DATA    2'h0
`define BDIV_IDX_LO_DATA    2'h1
`define BDIV_IDX_CTRL       2'h2
`define BDIV_IDX_MASK       2'h3
`define BDIV_RESP_OKAY      2'h0
`define BDIV_RESP_SLVERR    2'h2
`define BDIV_MASK_RESET     7'h7F
`define BDIV_VEC_BASE_NUM   8'h80
`define BDIV_LVL_NONE       3'h0
`define BDIV_LVL_ONE        3'h1
`define BDIV_LVL_TWO        3'h2
`define BDIV_LVL_THREE      3'h3
`define BDIV_LVL_SIX        3'h6
`define BDIV_BE_LO          2'h1
`define BDIV_BE_HI          2'h2
`define BDIV_BE_WORD        2'h3
`define BDIV_FIFO_DEPTH     2'h2
`define BDIV_MAX_XFER_RATE  150000
`endif

// >>> rtl/bdiv_pkg.sv
// board decode and interrupt vectoring: shared types
package bdiv_pkg;
  typedef struct packed {
    logic [1:0]  be;
    logic [15:0] data;
  } bdiv_word_t;

  typedef struct packed {
    logic [23:0] awaddr;
    logic        aw_got;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        w_got;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } bdiv_axi_t;

  typedef struct packed {
    bdiv_axi_t        axi;
    bdiv_word_t [1:0] fifo;
    logic [1:0]       fifo_cnt;
    logic             fifo_head;
    logic             in_ready;
    logic [15:0]      in_reg;
    logic             in_lo_full;
    logic             in_hi_full;
    logic [15:0]      out_reg;
    logic             out_lo_busy;
    logic             out_hi_busy;
    logic             out_valid;
    logic [15:0]      out_data;
    logic [1:0]       out_be;
    logic             oe_lo;
    logic             oe_hi;
    logic [6:0]       mask;
    logic             done_flag;
    logic [2:0]       irq_level;
    logic             iack_ack;
    logic [7:0]       iack_vector;
    logic             chain_out;
  } bdiv_state_t;
endpackage : bdiv_pkg

// >>> rtl/bdiv_top.sv
// board decode and interrupt vectoring with programmed parallel port
// Contract
// - registers decode at 0xFF8400 plus 0x10 times the base address switch value
// - all sources share one interrupt level chosen from one, two, three, six
// - never request at level four, five or seven
// - vector table base is 0x200 plus 0x20 times the vector base switch
// - seven sources, each with its own slot four bytes apart
// - slot zero unused; slot at base plus four is input word ready
// - slots 0x08..0x1C: input high, input low, output word/high/low, done
// - acknowledge answered only while the priority chain input is active
// - 16-bit input and output registers, each half with own status logic
// - host polls the status byte until ready, then moves the data
// - interrupt when input data waits or an output half can take data
// - port sustains word or byte transfers up to 150K per second
// - seven mask bits in the control low byte; one masks, zero enables
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bdiv_cfg.svh"

module bdiv_top #(
  parameter int ADDR_W = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        base_address_switch,
  input  wire logic [3:0]        vector_base_switch,
  input  wire logic [2:0]        level_jumper_a,
  input  wire logic [2:0]        level_jumper_b,
  input  wire logic              priority_chain_header,
  output      logic              priority_chain_out,
  input  wire logic              iack_req,
  input  wire logic [2:0]        iack_level,
  output      logic              iack_ack,
  output      logic [7:0]        iack_vector,
  output      logic [2:0]        irq_level,
  input  wire logic              in_valid,
  input  wire logic [15:0]       in_data,
  input  wire logic [1:0]        in_be,
  output      logic              in_ready,
  output      logic              out_valid,
  output      logic [15:0]       out_data,
  output      logic [1:0]        out_be,
  input  wire logic              out_ready,
  output      logic              out_drive_lo,
  output      logic              out_drive_hi,
  input  wire logic              transfer_done
);

  bdiv_pkg::bdiv_state_t s_q;
  bdiv_pkg::bdiv_state_t s_d;

  // returns {hit, index}; the block spans 16 bytes, one word per register
  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a,
                                            input logic [3:0] sw);
    logic [2:0] r;
    r = 3'h0;
    if (a[23:8] == `BDIV_BLOCK_HI && a[7:4] == sw && a[1:0] == 2'h0) begin
      r = {1'b1, a[3:2]};
    end
    return r;
  endfunction : reg_decode

  // a level is legal only if both jumpers agree and it is 1, 2, 3 or 6
  function automatic logic level_ok(input logic [2:0] a, input logic [2:0] b);
    logic ok;
    ok = (a == b) && (a == `BDIV_LVL_ONE || a == `BDIV_LVL_TWO ||
                      a == `BDIV_LVL_THREE || a == `BDIV_LVL_SIX);
    return ok;
  endfunction : level_ok

  logic [6:0] src_raw;
  logic [6:0] src_mask;
  logic [6:0] pending;
  logic [2:0] slot;
  logic [2:0] wdec;
  logic [2:0] rdec;
  logic [15:0] status_word;
  bdiv_pkg::bdiv_word_t head;

  always_comb begin
    // source n sits at slot n+1; slot 0 is never produced
    src_raw[0] = s_q.in_lo_full & s_q.in_hi_full;
    src_raw[1] = s_q.in_hi_full;
    src_raw[2] = s_q.in_lo_full;
    src_raw[3] = ~s_q.out_lo_busy & ~s_q.out_hi_busy;
    src_raw[4] = ~s_q.out_hi_busy;
    src_raw[5] = ~s_q.out_lo_busy;
    src_raw[6] = s_q.done_flag;
    // mask bit order runs opposite to the slot order
    for (int i = 0; i < 7; i++) begin
      src_mask[i] = s_q.mask[6 - i];
    end
    pending = src_raw & ~src_mask;
    slot = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (pending[i]) begin
        slot = 3'(i + 1);
      end
    end
    status_word = {s_q.oe_lo, s_q.oe_hi, src_raw[3], ~s_q.out_hi_busy,
                   ~s_q.out_lo_busy, src_raw[0], s_q.in_hi_full, s_q.in_lo_full,
                   1'b0, s_q.mask};
    wdec = reg_decode(s_q.axi.awaddr, base_address_switch);
    rdec = reg_decode(s_axi_araddr, base_address_switch);
    head = s_q.fifo[s_q.fifo_head];
  end

  always_comb begin
    logic       push;
    logic       pop;
    logic       lo_take;
    logic       hi_take;
    logic [1:0] send;
    push = 1'b0;
    pop = 1'b0;
    lo_take = 1'b0;
    hi_take = 1'b0;
    send = 2'h0;
    s_d = s_q;

    // write address and data are taken in either order
    if (s_axi_awvalid && s_q.axi.awready) begin
      s_d.axi.awaddr = s_axi_awaddr;
      s_d.axi.aw_got = 1'b1;
      s_d.axi.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.axi.wready) begin
      s_d.axi.wdata = s_axi_wdata[15:0];
      s_d.axi.wstrb = s_axi_wstrb[1:0];
      s_d.axi.w_got = 1'b1;
      s_d.axi.wready = 1'b0;
    end
    if (s_q.axi.aw_got && s_q.axi.w_got && !s_q.axi.bvalid) begin
      s_d.axi.aw_got = 1'b0;
      s_d.axi.w_got = 1'b0;
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = wdec[2] ? `BDIV_RESP_OKAY : `BDIV_RESP_SLVERR;
      if (wdec[2]) begin
        if (wdec[1:0] == `BDIV_IDX_HI_DATA) begin
          // lane 1 loads the high half, lane 0 the low half; busy halves ignore
          if (s_q.axi.wstrb[1] && !s_q.out_hi_busy) begin
            s_d.out_reg[15:8] = s_q.axi.wdata[15:8];
            s_d.out_hi_busy = 1'b1;
          end
          if (s_q.axi.wstrb[0] && !s_q.out_lo_busy) begin
            s_d.out_reg[7:0] = s_q.axi.wdata[7:0];
            s_d.out_lo_busy = 1'b1;
          end
        end else if (wdec[1:0] == `BDIV_IDX_LO_DATA) begin
          if (s_q.axi.wstrb[0] && !s_q.out_lo_busy) begin
            s_d.out_reg[7:0] = s_q.axi.wdata[7:0];
            s_d.out_lo_busy = 1'b1;
          end
        end else if (wdec[1:0] == `BDIV_IDX_CTRL) begin
          if (s_q.axi.wstrb[0]) begin
            s_d.mask = s_q.axi.wdata[6:0];
          end
          if (s_q.axi.wstrb[1]) begin
            s_d.oe_lo = s_q.axi.wdata[15];
            s_d.oe_hi = s_q.axi.wdata[14];
          end
        end else begin
          if (s_q.axi.wstrb[0]) begin
            s_d.mask = s_q.axi.wdata[6:0];
          end
        end
      end
    end
    if (s_q.axi.bvalid && s_axi_bready) begin
      s_d.axi.bvalid = 1'b0;
      s_d.axi.awready = 1'b1;
      s_d.axi.wready = 1'b1;
    end

    // read: one cycle from address to data, then hold until rready
    if (s_axi_arvalid && s_q.axi.arready) begin
      s_d.axi.arready = 1'b0;
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rresp = rdec[2] ? `BDIV_RESP_OKAY : `BDIV_RESP_SLVERR;
      s_d.axi.rdata = 32'h0000_0000;
      if (rdec[2]) begin
        if (rdec[1:0] == `BDIV_IDX_HI_DATA) begin
          s_d.axi.rdata = {16'h0000, s_q.in_reg};
          lo_take = 1'b1;
          hi_take = 1'b1;
        end else if (rdec[1:0] == `BDIV_IDX_LO_DATA) begin
          s_d.axi.rdata = {24'h00_0000, s_q.in_reg[7:0]};
          lo_take = 1'b1;
        end else if (rdec[1:0] == `BDIV_IDX_CTRL) begin
          s_d.axi.rdata = {16'h0000, status_word};
          s_d.done_flag = 1'b0;
        end else begin
          s_d.axi.rdata = {25'h000_0000, s_q.mask};
        end
      end
    end
    if (s_q.axi.rvalid && s_axi_rready) begin
      s_d.axi.rvalid = 1'b0;
      s_d.axi.arready = 1'b1;
    end

    // a done event in the clearing cycle wins over the read
    if (transfer_done) begin
      s_d.done_flag = 1'b1;
    end

    // input halves: a read empties them, the buffer refills them
    if (lo_take) begin
      s_d.in_lo_full = 1'b0;
    end
    if (hi_take) begin
      s_d.in_hi_full = 1'b0;
    end
    // the buffer drains only into halves the host has already emptied
    if (s_q.fifo_cnt != 2'h0 &&
        !(head.be[0] && s_q.in_lo_full) && !(head.be[1] && s_q.in_hi_full)) begin
      pop = 1'b1;
      if (head.be[0]) begin
        s_d.in_reg[7:0] = head.data[7:0];
        s_d.in_lo_full = 1'b1;
      end
      if (head.be[1]) begin
        s_d.in_reg[15:8] = head.data[15:8];
        s_d.in_hi_full = 1'b1;
      end
    end
    push = in_valid && s_q.in_ready && (in_be != 2'h0);
    if (push) begin
      s_d.fifo[s_q.fifo_head ^ s_q.fifo_cnt[0]] = '{be: in_be, data: in_data};
    end
    if (pop) begin
      s_d.fifo_head = ~s_q.fifo_head;
    end
    s_d.fifo_cnt = 2'(s_q.fifo_cnt + {1'b0, push} - {1'b0, pop});
    s_d.in_ready = (s_d.fifo_cnt != `BDIV_FIFO_DEPTH);

    // output halves leave only while their drivers are enabled
    if (s_q.out_valid && out_ready) begin
      s_d.out_valid = 1'b0;
      if (s_q.out_be[0]) begin
        s_d.out_lo_busy = 1'b0;
      end
      if (s_q.out_be[1]) begin
        s_d.out_hi_busy = 1'b0;
      end
    end else if (!s_q.out_valid) begin
      send = {s_q.out_hi_busy & s_q.oe_hi, s_q.out_lo_busy & s_q.oe_lo};
      if (send != 2'h0) begin
        s_d.out_valid = 1'b1;
        s_d.out_be = send;
        s_d.out_data = s_q.out_reg;
      end
    end

    // one shared level, legal values only
    s_d.irq_level = (level_ok(level_jumper_a, level_jumper_b) && slot != 3'h0) ?
                    level_jumper_a : `BDIV_LVL_NONE;

    // acknowledge: answer at our level, else pass the chain on
    s_d.iack_ack = 1'b0;
    s_d.chain_out = 1'b0;
    if (iack_req && priority_chain_header) begin
      if (s_q.irq_level != `BDIV_LVL_NONE && iack_level == s_q.irq_level &&
          slot != 3'h0) begin
        s_d.iack_ack = 1'b1;
        // vector number = (0x200 + 0x20*sw + 4*slot) / 4
        s_d.iack_vector = `BDIV_VEC_BASE_NUM + {1'b0, vector_base_switch, 3'h0}
                          + {5'h00, slot};
      end else begin
        s_d.chain_out = 1'b1;
      end
    end

    if (!aresetn) begin
      s_d = '0;
      s_d.axi.awready = 1'b1;
      s_d.axi.wready = 1'b1;
      s_d.axi.arready = 1'b1;
      s_d.mask = `BDIV_MASK_RESET;
      s_d.in_ready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign s_axi_awready      = s_q.axi.awready;
  assign s_axi_wready       = s_q.axi.wready;
  assign s_axi_bvalid       = s_q.axi.bvalid;
  assign s_axi_bresp        = s_q.axi.bresp;
  assign s_axi_arready      = s_q.axi.arready;
  assign s_axi_rvalid       = s_q.axi.rvalid;
  assign s_axi_rresp        = s_q.axi.rresp;
  assign s_axi_rdata        = s_q.axi.rdata;
  assign priority_chain_out = s_q.chain_out;
  assign iack_ack           = s_q.iack_ack;
  assign iack_vector        = s_q.iack_vector;
  assign irq_level          = s_q.irq_level;
  assign in_ready           = s_q.in_ready;
  assign out_valid          = s_q.out_valid;
  assign out_data           = s_q.out_data;
  assign out_be             = s_q.out_be;
  assign out_drive_lo       = s_q.oe_lo;
  assign out_drive_hi       = s_q.oe_hi;

endmodule : bdiv_top

// >>> verification/bdiv_props.sv
// assertion checker for the decode and vectoring block
`timescale 1ns/1ps
module bdiv_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        priority_chain_header,
  input wire logic        priority_chain_out,
  input wire logic        iack_req,
  input wire logic [2:0]  iack_level,
  input wire logic        iack_ack,
  input wire logic [7:0]  iack_vector,
  input wire logic [2:0]  irq_level,
  input wire logic [3:0]  vector_base_switch,
  input wire logic [2:0]  level_jumper_a,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic [1:0]  out_be,
  input wire logic        out_ready,
  input wire logic        out_drive_lo,
  input wire logic        out_drive_hi,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_lvl; irq_level inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6}; endproperty
  a_lvl: assert property (p_lvl) else $error("bad irq level");
  property p_jmp; irq_level != 3'h0 |-> irq_level == $past(level_jumper_a); endproperty
  a_jmp: assert property (p_jmp) else $error("irq level not jumper");
  property p_ack;
    iack_ack |-> $past(iack_req) && $past(priority_chain_header)
      && $past(iack_level) == $past(irq_level);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without cause");
  property p_vec;
    iack_ack |-> iack_vector[7:3] == {1'b1, $past(vector_base_switch)}
      && iack_vector[2:0] != 3'h0;
  endproperty
  a_vec: assert property (p_vec) else $error("vector off table");
  property p_chn; priority_chain_out |-> !iack_ack && $past(iack_req); endproperty
  a_chn: assert property (p_chn) else $error("chain out wrong");
  property p_drv; out_valid |-> (out_be & ~{out_drive_hi, out_drive_lo}) == 2'h0; endproperty
  a_drv: assert property (p_drv) else $error("half sent undriven");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_be);
  endproperty
  a_hold: assert property (p_hold) else $error("output word dropped");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_ack: cover property (iack_ack);
  c_chn: cover property (priority_chain_out);
  c_stall: cover property (out_valid && !out_ready);
endmodule : bdiv_props

bind bdiv_top bdiv_props u_props (.*);

// >>> verification/bdiv_peer.sv
// stream partner: word source into the port and stalling sink out of it
`timescale 1ns/1ps
module bdiv_peer (
  input  wire logic        aclk,
  input  wire logic        in_ready,
  output      logic        in_valid,
  output      logic [15:0] in_data,
  output      logic [1:0]  in_be,
  input  wire logic        out_valid,
  input  wire logic [15:0] out_data,
  input  wire logic [1:0]  out_be,
  output      logic        out_ready
);
  bdiv_pkg::bdiv_word_t q[$];
  bdiv_pkg::bdiv_word_t w;
  bdiv_pkg::bdiv_word_t got = 18'h00000;
  logic                 stall = 1'b0;
  initial begin
    in_valid = 1'b0;
    in_data = 16'h0000;
    in_be = 2'h0;
    out_ready = 1'b0;
  end
  task automatic send(input logic [15:0] d, input logic [1:0] b);
    q.push_back({b, d});
  endtask : send
  always @(posedge aclk) begin
    if (!in_valid || in_ready) begin
      if (q.size() > 0) begin
        w = q.pop_front();
        in_valid <= 1'b1;
        in_data <= w.data;
        in_be <= w.be;
      end else begin
        // idle lines toggle so no stale word looks valid
        in_valid <= 1'b0;
        in_data <= ~in_data;
      end
    end
    out_ready <= !stall;
    if (out_valid && out_ready) got <= {out_be, out_data};
  end
endmodule : bdiv_peer

// >>> verification/board_decode_interrupt_vectoring_tb.sv
// testbench: register, stream and acknowledge sequences
`timescale 1ns/1ps
module board_decode_interrupt_vectoring_tb;
  localparam logic [3:0] BSW = 4'h3;
  localparam logic [3:0] VSW = 4'h5;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic priority_chain_header = 1'b1, iack_req = 1'b0, transfer_done = 1'b0;
  logic [23:0] s_axi_awaddr = 24'h000000, s_axi_araddr = 24'h000000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0, base_address_switch = BSW, vector_base_switch = VSW;
  logic [2:0]  level_jumper_a = 3'h6, level_jumper_b = 3'h6, iack_level = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic priority_chain_out, iack_ack, in_valid, in_ready, out_valid, out_ready;
  logic out_drive_lo, out_drive_hi;
  logic [1:0]  s_axi_bresp, s_axi_rresp, in_be, out_be;
  logic [31:0] s_axi_rdata;
  logic [7:0]  iack_vector;
  logic [2:0]  irq_level;
  logic [15:0] in_data, out_data, d, r;
  int          num_errors = 0, compares = 0, cyc = 0;
  bdiv_top uut (.*);
  bdiv_peer peer (.*);
  initial forever #2 aclk = ~aclk;
  function automatic logic [23:0] ad(input logic [1:0] i);
    return {16'hFF84, BSW, i, 2'h0};
  endfunction : ad
  task automatic close_out();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [15:0] v, input logic [1:0] s,
                    input logic [15:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= {2'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ta && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!tw && s_axi_wready) s_axi_wvalid <= 1'b0;
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({14'h0000, s_axi_bresp}, er);
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [15:0] v, output logic [15:0] e);
    logic ta;
    ta = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ta && s_axi_arready) s_axi_arvalid <= 1'b0;
      ta = ta | s_axi_arready;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata[15:0];
    e = {14'h0000, s_axi_rresp};
  endtask : rd
  task automatic rc(input logic [23:0] a, input logic [15:0] e, input logic [15:0] er);
    rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask : rc
  // poll the word-ready status bit, then take the input word
  task automatic pw(input logic [15:0] e);
    do rd(ad(2'h2), d, r); while (d[10] !== 1'b1);
    rc(ad(2'h0), e, 16'h0000);
  endtask : pw
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(ad(2'h3), 16'h007F, 16'h0000);
    rc({16'hFF84, 8'h00}, 16'h0000, 16'h0002);
    wr({16'hFF84, 8'hF0}, 16'h1111, 2'h3, 16'h0002);
    peer.send(16'hA55A, 2'h3);
    pw(16'hA55A);
    for (int s = 1; s <= 7; s++) begin
      if (s <= 3) peer.send(16'h3CC3, (s == 1) ? 2'h3 : ((s == 2) ? 2'h2 : 2'h1));
      if (s == 7) begin
        @(posedge aclk);
        transfer_done <= 1'b1;
        @(posedge aclk);
        transfer_done <= 1'b0;
      end
      wr(ad(2'h3), {9'h000, ~(7'h40 >> (s - 1))}, 2'h1, 16'h0000);
      repeat (3) @(posedge aclk);
      chk({13'h0000, irq_level}, 16'h0006);
      if (s == 1) begin
        priority_chain_header <= 1'b0;
        iack_level <= 3'h6;
        iack_req <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({15'h0000, iack_ack}, 16'h0000);
        priority_chain_header <= 1'b1;
        iack_level <= 3'h3;
        repeat (2) @(posedge aclk);
        chk({14'h0000, iack_ack, priority_chain_out}, 16'h0001);
      end
      iack_level <= 3'h6;
      iack_req <= 1'b1;
      repeat (2) @(posedge aclk);
      chk({8'h00, iack_vector}, {8'h00, 8'h80 + {VSW, 3'h0} + 8'(s)});
      iack_req <= 1'b0;
      wr(ad(2'h3), 16'h007F, 2'h1, 16'h0000);
      rd(ad(2'h0), d, r);
      rd(ad(2'h2), d, r);
    end
    chk({13'h0000, irq_level}, 16'h0000);
    wr(ad(2'h3), 16'h0077, 2'h1, 16'h0000);
    for (int j = 0; j < 9; j++) begin
      level_jumper_a <= j[2:0];
      level_jumper_b <= (j == 8) ? 3'h3 : j[2:0];
      repeat (3) @(posedge aclk);
      chk({13'h0000, irq_level}, (j inside {1, 2, 3, 6}) ? 16'(j) : 16'h0000);
    end
    peer.stall <= 1'b1;
    wr(ad(2'h2), 16'hC07F, 2'h3, 16'h0000);
    wr(ad(2'h0), 16'h1234, 2'h3, 16'h0000);
    repeat (4) @(posedge aclk);
    chk(out_data, 16'h1234);
    rc(ad(2'h2), 16'hC07F, 16'h0000);
    peer.stall <= 1'b0;
    repeat (4) @(posedge aclk);
    rc(ad(2'h2), 16'hF87F, 16'h0000);
    wr(ad(2'h1), 16'h005A, 2'h1, 16'h0000);
    repeat (6) @(posedge aclk);
    chk(peer.got[15:0], 16'h125A);
    chk({14'h0000, peer.got[17:16]}, 16'h0001);
    for (int k = 1; k <= 4; k++) peer.send(16'(k), 2'h3);
    repeat (10) @(posedge aclk);
    chk({15'h0000, in_ready}, 16'h0000);
    for (int k = 1; k <= 4; k++) pw(16'(k));
    // a low-only byte: poll the low ready bit, read it alone, flag must clear
    peer.send(16'h5AA5, 2'h1);
    do rd(ad(2'h2), d, r); while (d[8] !== 1'b1);
    rc(ad(2'h1), 16'h00A5, 16'h0000);
    rc(ad(2'h2), 16'hF87F, 16'h0000);
    close_out();
  end
endmodule : board_decode_interrupt_vectoring_tb
